// *** mmsc_defines.vh ***
// Constants for the memory map and select configuration block.
// Assumes inclusion by bare name from the design file in the same folder.
`ifndef MMSC_DEFINES_VH
`define MMSC_DEFINES_VH

// ==========================================================================
// Register offsets on the plain register port
// ==========================================================================
`define MMSC_OFF_MODE      4'h0
`define MMSC_OFF_ID_LOW    4'h1
`define MMSC_OFF_ID_HIGH   4'h2
`define MMSC_OFF_PAGE      4'h3
`define MMSC_OFF_MAIN_PROT 4'h4
`define MMSC_OFF_BOOT_PROT 4'h5
`define MMSC_OFF_FLASH_CTL 4'h6
`define MMSC_OFF_STATUS    4'h7

// ==========================================================================
// Mode register fields
// ==========================================================================
`define MMSC_BIT_SRAM_FETCH  0
`define MMSC_BIT_BOOT_FETCH  1
`define MMSC_BIT_MAIN_FETCH  2
`define MMSC_BIT_BOOT_READ   3
`define MMSC_BIT_MAIN_READ   4
`define MMSC_BIT_PERIPH      7
`define MMSC_MODE_WMASK      8'h9F

// ==========================================================================
// Identification codes
// ==========================================================================
`define MMSC_FSIZE_2MBIT  4'h4
`define MMSC_FSIZE_8MBIT  4'h5
`define MMSC_SSIZE_NONE   4'h0
`define MMSC_SSIZE_16KBIT 4'h1
`define MMSC_SSIZE_64KBIT 4'h3
`define MMSC_BSIZE_NONE   4'h0
`define MMSC_BSIZE_256K   4'h2
`define MMSC_BTYPE_FLASH  2'h0

// ==========================================================================
// Flash control register fields and sector geometry
// ==========================================================================
`define MMSC_CTL_PROGRAM  0
`define MMSC_CTL_ERASE    1
`define MMSC_CTL_SUSPEND  2
`define MMSC_CTL_RESUME   3
`define MMSC_CTL_BOOT     4
`define MMSC_CTL_RDYEN    7
`define MMSC_MAIN_SECTORS 8
`define MMSC_BOOT_SECTORS 4
`define MMSC_TERMS        3
`define MMSC_PAGE_RESET   8'h00
`define MMSC_PROG_CYCLES  8'h10
`define MMSC_ERASE_CYCLES 8'hFF

`endif

// *** mmsc_host_model.sv ***
// Host bus model: turns a requested cycle kind into fetch or read strobes.
// Assumes the bench changes cycleKind off the clock edge or by non-blocking assignment.
`timescale 1ns/1ns
`default_nettype none
module mmsc_host_model (
    input  wire logic       clk,
    input  wire logic [1:0] cycleKind,
    output var  logic       programFetchStrobe = 1'b0,
    output var  logic       readStrobe = 1'b0
);
    // Never both strobes at once, as a real bus cycle is fetch or read.
    always @(posedge clk) begin
        programFetchStrobe <= (cycleKind == 2'h1);
        readStrobe <= (cycleKind == 2'h2);
    end
endmodule
`default_nettype wire

// *** mmsc_memory_map.v ***
// Memory map select and configuration logic: mode register, identification
// registers, page register, sector selects, block half address and a
// simple flash operation sequencer with protection and erase suspend.
// Assumes a host that drives the register port synchronously to clk and
// product-term match vectors computed by the surrounding decode logic.
//
// Local design decisions: the strobed register port and the address map.
`include "mmsc_defines.vh"
`timescale 1ns/1ns
`default_nettype none

module mmsc_memory_map #(
    parameter [3:0] MAIN_SIZE_CODE = `MMSC_FSIZE_8MBIT,
    parameter [3:0] SRAM_SIZE_CODE = `MMSC_SSIZE_64KBIT,
    parameter [3:0] BOOT_SIZE_CODE = `MMSC_BSIZE_256K
) (
    input  wire        clk,
    input  wire        rst,
    input  wire [3:0]  regAddr,
    input  wire [7:0]  regWrData,
    input  wire        regWrite,
    input  wire        regRead,
    output reg  [7:0]  regRdData,
    input  wire [3:0]  cfgModeDefault,
    input  wire        extendedBusMode,
    input  wire        blockEquationUsed,
    input  wire [2:0]  blockTermMatch,
    input  wire        hostA15,
    input  wire [23:0] mainTermMatch,
    input  wire [11:0] bootTermMatch,
    input  wire        programFetchStrobe,
    input  wire        readStrobe,
    input  wire        sramSelect,
    output reg         sramEnable,
    output reg  [7:0]  mainSectorSelects,
    output reg  [3:0]  bootSectorSelects,
    output reg         mainFlashEnable,
    output reg         bootFlashEnable,
    output reg         blockHalfAddress,
    output reg         portFPeriphMode,
    output reg  [7:0]  pageValue,
    output reg         readyBusyOut,
    output reg         readyBusyOe
);

// ==========================================================================
// Helpers
// ==========================================================================
    // Gate applied to a mode access bit: outside extended mode it always passes.
    function gateBit;
        input allow;
        input extMode;
        begin
            gateBit = allow | ~extMode;
        end
    endfunction

    // A write strobe aimed at the flash control register. Start, suspend and
    // resume all decode it, so the three cannot drift apart.
    function ctlWrite;
        input       wrStrobe;
        input [3:0] addr;
        begin
            ctlWrite = wrStrobe && (addr == `MMSC_OFF_FLASH_CTL);
        end
    endfunction

// ==========================================================================
// Declarations
// ==========================================================================
    // Sequencer states; the status register shows these codes directly.
    localparam [1:0] ST_IDLE    = 2'd0;
    localparam [1:0] ST_PROGRAM = 2'd1;
    localparam [1:0] ST_ERASE   = 2'd2;
    localparam [1:0] ST_SUSPEND = 2'd3;

    reg [7:0] modeQ;
    reg [7:0] pageQ;
    reg [7:0] mainProtQ;
    reg [3:0] bootProtQ;
    reg       rdyEnQ;
    reg [1:0] stateQ;
    // Eight bits cover the longest operation, a full sector erase.
    reg [7:0] countQ;
    reg       opBootQ;
    reg [2:0] opSectorQ;
    reg [7:0] rdD;
    reg [1:0] stateD;
    reg [7:0] countD;

    wire [7:0] mainSel;
    wire [3:0] bootSel;
    wire       opStart;
    wire       opProtected;
    wire       eraseActive;

// ==========================================================================
// Sector selects
// ==========================================================================
    // Each sector select is an OR of three product terms; several address
    // regions may therefore map onto the same sector.
    // The selects are not qualified by any strobe; the enables do that.
    genvar gi;
    generate
        for (gi = 0; gi < `MMSC_MAIN_SECTORS; gi = gi + 1) begin : gMain
            assign mainSel[gi] = |mainTermMatch[gi*`MMSC_TERMS +: `MMSC_TERMS];
        end
        for (gi = 0; gi < `MMSC_BOOT_SECTORS; gi = gi + 1) begin : gBoot
            assign bootSel[gi] = |bootTermMatch[gi*`MMSC_TERMS +: `MMSC_TERMS];
        end
    endgenerate

// ==========================================================================
// Flash operation sequencer
// ==========================================================================
    // Operations start only from idle. A command written while busy is
    // dropped without any error flag, so software polls the status first.
    assign opStart = ctlWrite(regWrite, regAddr) && stateQ == ST_IDLE &&
                     (regWrData[`MMSC_CTL_PROGRAM] || regWrData[`MMSC_CTL_ERASE]);
    // Boot targets share bits 1:0 with the command bits: a boot program always
    // hits sector 1, a boot erase sector 2, or sector 3 with both bits set.
    // This is the price of keeping the whole command in one byte.
    // protection check
    assign opProtected = regWrData[`MMSC_CTL_BOOT] ? bootProtQ[regWrData[1:0]]
                                                   : mainProtQ[regWrData[6:4]];
    // A suspended erase lets the block equation act again, since the host
    // then reads from other sectors.
    assign eraseActive = (stateQ == ST_ERASE);

    always @* begin
        stateD = stateQ;
        countD = countQ;
        case (stateQ)
            ST_IDLE: begin
                if (opStart && !opProtected) begin
                    stateD = regWrData[`MMSC_CTL_ERASE] ? ST_ERASE : ST_PROGRAM;
                    countD = regWrData[`MMSC_CTL_ERASE] ? `MMSC_ERASE_CYCLES
                                                        : `MMSC_PROG_CYCLES;
                end
            end
            ST_PROGRAM: begin
                countD = countQ - 8'h01;
                if (countQ == 8'h01) begin
                    stateD = ST_IDLE;
                end
            end
            ST_ERASE: begin
                countD = countQ - 8'h01;
                // Suspend freezes the count so resume continues where it stopped.
                // suspend erase
                if (ctlWrite(regWrite, regAddr) && regWrData[`MMSC_CTL_SUSPEND]) begin
                    stateD = ST_SUSPEND;
                    countD = countQ;
                end else if (countQ == 8'h01) begin
                    stateD = ST_IDLE;
                end
            end
            ST_SUSPEND: begin
                if (ctlWrite(regWrite, regAddr) && regWrData[`MMSC_CTL_RESUME]) begin
                    stateD = ST_ERASE;
                end
            end
            default: begin
                stateD = ST_IDLE;
            end
        endcase
    end

// ==========================================================================
// Registers and read path
// ==========================================================================
    // Unmapped offsets read zero so that software can probe the map safely.
    always @* begin
        rdD = 8'h00;
        case (regAddr)
            `MMSC_OFF_MODE:      rdD = modeQ & `MMSC_MODE_WMASK;
            `MMSC_OFF_ID_LOW:    rdD = {SRAM_SIZE_CODE, MAIN_SIZE_CODE};
            `MMSC_OFF_ID_HIGH:   rdD = {2'b00, `MMSC_BTYPE_FLASH, BOOT_SIZE_CODE};
            `MMSC_OFF_PAGE:      rdD = pageQ;
            `MMSC_OFF_MAIN_PROT: rdD = mainProtQ;
            `MMSC_OFF_BOOT_PROT: rdD = {4'h0, bootProtQ};
            `MMSC_OFF_FLASH_CTL: rdD = {rdyEnQ, 7'h00};
            // Status keeps the last accepted operation; a refused one leaves it.
            `MMSC_OFF_STATUS:    rdD = {opBootQ, opSectorQ, 2'b00, stateQ};
            default:             rdD = 8'h00;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            modeQ     <= {3'b000, cfgModeDefault, 1'b0};
            pageQ     <= `MMSC_PAGE_RESET;
            mainProtQ <= 8'h00;
            bootProtQ <= 4'h0;
            rdyEnQ    <= 1'b0;
            stateQ    <= ST_IDLE;
            countQ    <= 8'h00;
            opBootQ   <= 1'b0;
            opSectorQ <= 3'b000;
            regRdData <= 8'h00;
        end else begin
            stateQ    <= stateD;
            countQ    <= countD;
            // Read data are zero outside the answer cycle, so several sources
            // may be ORed onto one host bus without extra selects.
            regRdData <= regRead ? rdD : 8'h00;
            if (regWrite) begin
                case (regAddr)
                    // Bits 5 and 6 are dropped here so reads always return zero there.
                    `MMSC_OFF_MODE:      modeQ <= regWrData & `MMSC_MODE_WMASK;
                    `MMSC_OFF_PAGE:      pageQ <= regWrData;
                    // Protection bits are set by software only; no hardware event other than reset clears them.
                    `MMSC_OFF_MAIN_PROT: mainProtQ <= regWrData;
                    `MMSC_OFF_BOOT_PROT: bootProtQ <= regWrData[3:0];
                    `MMSC_OFF_FLASH_CTL: rdyEnQ <= regWrData[`MMSC_CTL_RDYEN];
                    default: begin
                    end
                endcase
            end
            if (opStart && !opProtected) begin
                opBootQ   <= regWrData[`MMSC_CTL_BOOT];
                opSectorQ <= regWrData[`MMSC_CTL_BOOT] ? {1'b0, regWrData[1:0]}
                                                       : regWrData[6:4];
            end
        end
    end

// ==========================================================================
// Access enables and sector selects
// ==========================================================================
    // Every enable is registered so the host sees clean levels; the price is
    // one clock of latency behind the strobes and the decode terms.
    always @(posedge clk) begin
        if (rst) begin
            sramEnable        <= 1'b0;
            mainSectorSelects <= 8'h00;
            bootSectorSelects <= 4'h0;
            mainFlashEnable   <= 1'b0;
            bootFlashEnable   <= 1'b0;
        end else begin
            // An SRAM read is never gated; only fetches need the mode bit.
            // extended mode gating
            sramEnable <= sramSelect & ((programFetchStrobe &
                          gateBit(modeQ[`MMSC_BIT_SRAM_FETCH], extendedBusMode)) | readStrobe);
            mainSectorSelects <= mainSel;
            bootSectorSelects <= bootSel;
            mainFlashEnable <= (|mainSel) &
                ((programFetchStrobe & gateBit(modeQ[`MMSC_BIT_MAIN_FETCH], extendedBusMode)) |
                 (readStrobe & gateBit(modeQ[`MMSC_BIT_MAIN_READ], extendedBusMode)));
            bootFlashEnable <= (|bootSel) &
                ((programFetchStrobe & gateBit(modeQ[`MMSC_BIT_BOOT_FETCH], extendedBusMode)) |
                 (readStrobe & gateBit(modeQ[`MMSC_BIT_BOOT_READ], extendedBusMode)));
        end
    end

// ==========================================================================
// Block half address
// ==========================================================================
    // Registering the half address keeps it aligned with the sector selects.
    always @(posedge clk) begin
        if (rst) begin
            blockHalfAddress <= 1'b0;
        end else begin
            // One shared line feeds every main sector; there is no per-sector copy.
            // shared by all sectors
            if (blockEquationUsed && !eraseActive) begin
                blockHalfAddress <= |blockTermMatch;
            end else begin
                blockHalfAddress <= hostA15;
            end
        end
    end

// ==========================================================================
// Port mode, page and ready/busy
// ==========================================================================
    always @(posedge clk) begin
        if (rst) begin
            portFPeriphMode <= 1'b0;
            pageValue       <= `MMSC_PAGE_RESET;
            readyBusyOut    <= 1'b1;
            readyBusyOe     <= 1'b0;
        end else begin
            portFPeriphMode <= modeQ[`MMSC_BIT_PERIPH];
            pageValue <= pageQ;
            // The pin follows the next state, so it falls in the same clock in
            // which the sequencer enters program or erase. A suspended erase
            // reports ready, since the host may then read the flash again.
            // ready/busy pin
            readyBusyOut <= (stateD == ST_IDLE) || (stateD == ST_SUSPEND);
            readyBusyOe  <= rdyEnQ;
        end
    end

endmodule
`default_nettype wire

// *** mmsc_memory_map_chk.sv ***
// Concurrent checks on the ports of the memory map block.
// Assumes registered outputs with one cycle of latency and a synchronous reset.
`timescale 1ns/1ns
`default_nettype none
module mmsc_memory_map_chk #(
    parameter [3:0] MAIN_SIZE_CODE = 4'h5,
    parameter [3:0] SRAM_SIZE_CODE = 4'h3,
    parameter [3:0] BOOT_SIZE_CODE = 4'h2
) (
    input wire        clk,
    input wire        rst,
    input wire [3:0]  regAddr,
    input wire        regRead,
    input wire [7:0]  regRdData,
    input wire        extendedBusMode,
    input wire        blockEquationUsed,
    input wire        hostA15,
    input wire [23:0] mainTermMatch,
    input wire [11:0] bootTermMatch,
    input wire        programFetchStrobe,
    input wire        readStrobe,
    input wire        sramSelect,
    input wire        sramEnable,
    input wire [7:0]  mainSectorSelects,
    input wire [3:0]  bootSectorSelects,
    input wire        blockHalfAddress,
    input wire        portFPeriphMode,
    input wire [7:0]  pageValue
);
    // ======================================================================
    // Assertions
    // ======================================================================
    // The $past(rst) guards keep a check from judging the first edge after reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_block_pass: assert property (
        !$past(rst) && !$past(blockEquationUsed) |-> blockHalfAddress == $past(hostA15))
        else $error("host A15 not passed to the flash");
    a_main_sel: assert property (
        !$past(rst) |-> mainSectorSelects[0] == |$past(mainTermMatch[2:0])
            && mainSectorSelects[7] == |$past(mainTermMatch[23:21]))
        else $error("main sector select wrong");
    a_boot_sel: assert property (
        !$past(rst) |-> bootSectorSelects[3] == |$past(bootTermMatch[11:9]))
        else $error("boot sector select wrong");
    a_id_low: assert property (
        !$past(rst) && $past(regRead && regAddr == 4'h1)
            |-> regRdData == {SRAM_SIZE_CODE, MAIN_SIZE_CODE})
        else $error("first id register wrong");
    a_id_high: assert property (
        !$past(rst) && $past(regRead && regAddr == 4'h2)
            |-> regRdData == {4'h0, BOOT_SIZE_CODE})
        else $error("second id register wrong");
    a_mode_unused: assert property (
        !$past(rst) && $past(regRead && regAddr == 4'h0) |-> regRdData[6:5] == 2'h0)
        else $error("unused mode bits not zero");
    a_reset_vals: assert property (
        $past(rst) |-> pageValue == 8'h00 && !portFPeriphMode)
        else $error("reset values wrong");
    a_sram_gate: assert property (
        !$past(rst) && !$past(extendedBusMode)
            |-> sramEnable == $past(sramSelect && (programFetchStrobe || readStrobe)))
        else $error("sram enable wrong outside extended mode");
endmodule
bind mmsc_memory_map mmsc_memory_map_chk #(
    .MAIN_SIZE_CODE(MAIN_SIZE_CODE),
    .SRAM_SIZE_CODE(SRAM_SIZE_CODE),
    .BOOT_SIZE_CODE(BOOT_SIZE_CODE)
) u_chk (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regRead(regRead), .regRdData(regRdData),
    .extendedBusMode(extendedBusMode), .blockEquationUsed(blockEquationUsed),
    .hostA15(hostA15), .mainTermMatch(mainTermMatch), .bootTermMatch(bootTermMatch),
    .programFetchStrobe(programFetchStrobe), .readStrobe(readStrobe),
    .sramSelect(sramSelect), .sramEnable(sramEnable), .mainSectorSelects(mainSectorSelects),
    .bootSectorSelects(bootSectorSelects), .blockHalfAddress(blockHalfAddress),
    .portFPeriphMode(portFPeriphMode), .pageValue(pageValue)
);
`default_nettype wire

// *** test_mmsc_memory_map.sv ***
// Self-checking bench for the memory map block with the host bus model.
// Assumes the default size-code parameters of the design.
`include "mmsc_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module test_mmsc_memory_map;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  regAddr = 4'h0;
    logic [7:0]  regWrData = 8'h00;
    logic        regWrite = 1'b0;
    logic        regRead = 1'b0;
    logic [3:0]  cfgModeDefault = 4'hA;
    logic        extUsed = 1'b1;
    logic        eqUsed = 1'b0;
    logic [2:0]  blockTerms = 3'h0;
    logic        hostA15 = 1'b0;
    logic [23:0] mainTerms = 24'h00_0001;
    logic [11:0] bootTerms = 12'h001;
    logic        sramSelect = 1'b1;
    logic [1:0]  cycleKind = 2'h0;
    logic        pfs, rds, sramEn, mainEn, bootEn, bha, periph, rdy, rdyOe;
    logic [7:0]  regRdData, mainSel, pageVal;
    logic [3:0]  bootSel;
    int          bad_count = 0;
    int          cmp_count = 0;
    mmsc_host_model u_host (.clk(clk), .cycleKind(cycleKind),
        .programFetchStrobe(pfs), .readStrobe(rds));
    mmsc_memory_map u_dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .cfgModeDefault(cfgModeDefault), .extendedBusMode(extUsed),
        .blockEquationUsed(eqUsed), .blockTermMatch(blockTerms), .hostA15(hostA15),
        .mainTermMatch(mainTerms), .bootTermMatch(bootTerms), .programFetchStrobe(pfs),
        .readStrobe(rds), .sramSelect(sramSelect), .sramEnable(sramEn),
        .mainSectorSelects(mainSel), .bootSectorSelects(bootSel), .mainFlashEnable(mainEn),
        .bootFlashEnable(bootEn), .blockHalfAddress(bha), .portFPeriphMode(periph),
        .pageValue(pageVal), .readyBusyOut(rdy), .readyBusyOe(rdyOe));
    initial begin
        forever #20 clk = ~clk;
    end
    // ======================================================================
    // Bus, compare and closing tasks
    // ======================================================================
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        chk(n, {7'h00, e}, {7'h00, g});
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 chk("regRdData", e, regRdData & m);
    endtask
    // Three edges cover the host register and the enable, which registers beside the selects, with one edge to spare.
    task automatic drive(input logic [1:0] k);
        @(posedge clk);
        cycleKind <= k;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ======================================================================
    // Scenarios
    // ======================================================================
    task automatic t_regs;
        rd(`MMSC_OFF_MODE, 8'h14, 8'hFF);
        wr(`MMSC_OFF_MODE, 8'h9F);
        rd(`MMSC_OFF_MODE, 8'h9F, 8'hFF);
        chk1("periph", 1'b1, periph);
        @(posedge clk);
        rst <= 1'b1;
        cfgModeDefault <= 4'h5;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(`MMSC_OFF_MODE, 8'h0A, 8'hFF);
        chk1("periph", 1'b0, periph);
        wr(`MMSC_OFF_ID_LOW, 8'h00);
        rd(`MMSC_OFF_ID_LOW, 8'h35, 8'hFF);
        rd(`MMSC_OFF_ID_HIGH, 8'h02, 8'hFF);
        rd(4'hF, 8'h00, 8'hFF);
        chk("pageVal", 8'h00, pageVal);
        wr(`MMSC_OFF_PAGE, 8'h10);
        rd(`MMSC_OFF_PAGE, 8'h10, 8'hFF);
        chk("pageVal", 8'h10, pageVal);
    endtask
    task automatic t_gate;
        logic [4:0] m;
        logic       x;
        for (int i = 0; i < 6; i++) begin
            m = (i < 5) ? (5'h01 << i) : 5'h00;
            x = (i == 5);
            @(posedge clk);
            extUsed <= !x;
            wr(`MMSC_OFF_MODE, {3'h0, m});
            drive(2'h1);
            chk1("sramFetch", x | m[0], sramEn);
            chk1("bootFetch", x | m[1], bootEn);
            chk1("mainFetch", x | m[2], mainEn);
            drive(2'h2);
            chk1("sramRead", 1'b1, sramEn);
            chk1("bootRead", x | m[3], bootEn);
            chk1("mainRead", x | m[4], mainEn);
        end
        @(posedge clk);
        sramSelect <= 1'b0;
        drive(2'h1);
        chk1("sramUnsel", 1'b0, sramEn);
        @(posedge clk);
        sramSelect <= 1'b1;
        cycleKind <= 2'h0;
    endtask
    task automatic t_block;
        @(posedge clk);
        eqUsed <= 1'b1;
        blockTerms <= 3'h2;
        mainTerms <= 24'h80_0000;
        bootTerms <= 12'h800;
        drive(2'h0);
        chk1("halfEq", 1'b1, bha);
        chk("mainSel", 8'h80, mainSel);
        chk("bootSel", 8'h08, {4'h0, bootSel});
        @(posedge clk);
        eqUsed <= 1'b0;
        blockTerms <= 3'h0;
        hostA15 <= 1'b1;
        drive(2'h0);
        chk1("halfHost", 1'b1, bha);
    endtask
    task automatic t_flash;
        wr(`MMSC_OFF_MAIN_PROT, 8'h04);
        wr(`MMSC_OFF_FLASH_CTL, 8'h22);
        rd(`MMSC_OFF_STATUS, 8'h00, 8'h03);
        @(posedge clk);
        eqUsed <= 1'b1;
        blockTerms <= 3'h1;
        hostA15 <= 1'b0;
        wr(`MMSC_OFF_FLASH_CTL, 8'h82);
        rd(`MMSC_OFF_STATUS, 8'h02, 8'h03);
        chk1("busy", 1'b0, rdy);
        chk1("busyOe", 1'b1, rdyOe);
        chk1("halfErase", 1'b0, bha);
        wr(`MMSC_OFF_FLASH_CTL, 8'h04);
        rd(`MMSC_OFF_STATUS, 8'h03, 8'h03);
        wr(`MMSC_OFF_FLASH_CTL, 8'h08);
        rd(`MMSC_OFF_STATUS, 8'h02, 8'h03);
        repeat (300) @(posedge clk);
        rd(`MMSC_OFF_STATUS, 8'h00, 8'h03);
        chk1("ready", 1'b1, rdy);
        wr(`MMSC_OFF_BOOT_PROT, 8'h02);
        wr(`MMSC_OFF_FLASH_CTL, 8'h11);
        rd(`MMSC_OFF_STATUS, 8'h00, 8'h03);
        wr(`MMSC_OFF_BOOT_PROT, 8'h00);
        wr(`MMSC_OFF_FLASH_CTL, 8'h11);
        rd(`MMSC_OFF_STATUS, 8'h91, 8'hFF);
        chk1("busyProg", 1'b0, rdy);
        repeat (20) @(posedge clk);
        rd(`MMSC_OFF_STATUS, 8'h00, 8'h03);
        chk1("readyProg", 1'b1, rdy);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_gate;
        t_block;
        t_flash;
        final_report;
    end
    initial begin
        #(40 * 5000);
        bad_count++;
        final_report;
    end
endmodule
`default_nettype wire
